/* File: hw/bex_pkg.sv */
// constants and types of the bit and data transfer execution unit
// assumes one core clock and a decoder upstream that fills bex_instr_t
package bex_pkg;

  // ---------------------------------------------------------------
  // register map of the software port
  // ---------------------------------------------------------------
  localparam int unsigned REG_CNT      = 32;
  localparam logic [5:0]  RA_STATUS    = 6'h20;
  localparam logic [5:0]  RA_SP_LO     = 6'h21;
  localparam logic [5:0]  RA_SP_HI     = 6'h22;
  localparam logic [7:0]  GPR_RESET    = 8'h00;
  localparam logic [7:0]  STATUS_RESET = 8'h00;
  localparam logic [15:0] SP_RESET     = 16'h0000;

  // ---------------------------------------------------------------
  // status flag positions and pointer register numbers
  // ---------------------------------------------------------------
  localparam logic [2:0] FL_C = 3'h0;
  localparam logic [2:0] FL_Z = 3'h1;
  localparam logic [2:0] FL_N = 3'h2;
  localparam logic [2:0] FL_V = 3'h3;
  localparam logic [2:0] FL_S = 3'h4;
  localparam logic [2:0] FL_H = 3'h5;
  localparam logic [2:0] FL_T = 3'h6;
  localparam logic [2:0] FL_I = 3'h7;
  localparam logic [4:0] PTR_X_LO = 5'h1a;
  localparam logic [4:0] PTR_Y_LO = 5'h1c;
  localparam logic [4:0] PTR_Z_LO = 5'h1e;
  localparam logic [4:0] PM_DEFAULT_RD = 5'h00;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_SET_IO_BIT, OP_CLR_IO_BIT, OP_SHIFT_LEFT, OP_SHIFT_RIGHT,
    OP_SHIFT_ARITH, OP_ROT_LEFT, OP_ROT_RIGHT, OP_SWAP, OP_FLAG_SET,
    OP_FLAG_CLR, OP_BIT_TO_T, OP_T_TO_BIT, OP_COPY, OP_PAIR_COPY, OP_IMM,
    OP_LOAD_IND, OP_LOAD_DISP, OP_LOAD_DIR, OP_STORE_IND, OP_STORE_DISP,
    OP_STORE_DIR, OP_PM_READ, OP_PORT_IN, OP_PORT_OUT, OP_PUSH, OP_POP
  } bex_op_t;

  typedef enum logic [1:0] {PS_X, PS_Y, PS_Z, PS_NONE} bex_ptr_t;
  typedef enum logic [1:0] {AM_PLAIN, AM_POST_INC, AM_PRE_DEC} bex_amode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_SECOND = 2'b01, ST_THIRD = 2'b11
  } bex_state_t;

  typedef struct packed {
    bex_op_t    op;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [2:0] bsel;
    logic [5:0] io;
    logic [15:0] k;
    bex_ptr_t   ptr;
    bex_amode_t mode;
  } bex_instr_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } bex_mem_req_t;

  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] data;
    logic       we;
  } bex_io_wr_t;

endpackage

/* File: hw/bex_exec.sv */
// execution unit for bit, shift, flag and data transfer instructions
// assumes a decoded instruction upstream, data memory and program memory
// with combinational read in the strobe cycle, and an i/o space whose read
// port answers in the same cycle
`timescale 1ns/1ps

module bex_exec (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // instruction issue
  input  wire bex_pkg::bex_instr_t   instr,
  input  wire logic                  instr_valid,
  output logic                       instr_ready,
  output logic                       done,
  // software register port
  input  wire logic [5:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_we,
  input  wire logic                  reg_re,
  output logic [7:0]                 reg_rdata,
  // data memory
  output bex_pkg::bex_mem_req_t      dmem_req,
  input  wire logic [7:0]            dmem_rdata,
  // i/o space
  output logic [5:0]                 io_raddr,
  output logic                       io_re,
  input  wire logic [7:0]            io_rdata,
  output bex_pkg::bex_io_wr_t        io_wr,
  // program memory
  output logic [15:0]                pmem_addr,
  output logic                       pmem_re,
  input  wire logic [7:0]            pmem_rdata,
  // state
  output logic [7:0]                 status_flags,
  output logic [15:0]                stack_ptr
);
  import bex_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [8:0] bex_shift(bex_op_t op, logic [7:0] v,
                                           logic c);
    logic [8:0] r;
    r = {c, v};
    case (op)
      OP_SHIFT_LEFT:  r = {v[7], v[6:0], 1'b0};
      OP_SHIFT_RIGHT: r = {v[0], 1'b0, v[7:1]};
      OP_SHIFT_ARITH: r = {v[0], v[7], v[7:1]};
      OP_ROT_LEFT:    r = {v[7], v[6:0], c};
      OP_ROT_RIGHT:   r = {v[0], c, v[7:1]};
      OP_SWAP:        r = {c, v[3:0], v[7:4]};
      default:        r = {c, v};
    endcase
    return r;
  endfunction

  function automatic logic [7:0] bex_shift_flags(logic [7:0] s,
                                                 logic [8:0] r);
    logic [7:0] f;
    f       = s;
    f[FL_C] = r[8];
    f[FL_Z] = (r[7:0] == 8'h00);
    f[FL_N] = r[7];
    f[FL_V] = r[7] ^ r[8];
    return f;
  endfunction

  function automatic logic [4:0] bex_ptr_base(bex_ptr_t p);
    logic [4:0] b;
    b = PTR_Z_LO;
    if (p == PS_X) b = PTR_X_LO;
    if (p == PS_Y) b = PTR_Y_LO;
    return b;
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0]   gpr [REG_CNT];
  bex_state_t   state_reg,  state_next;
  bex_instr_t   cur_reg;
  logic [7:0]   status_reg, status_next;
  logic [15:0]  sp_reg,     sp_next;
  bex_mem_req_t dmem_reg,   dmem_next;
  bex_io_wr_t   io_wr_reg,  io_wr_next;
  logic [15:0]  pmem_addr_reg;
  logic         pmem_re_reg;
  logic [7:0]   pm_byte_reg;
  logic         done_reg,   done_next;
  logic [7:0]   reg_rdata_reg;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire          accept   = instr_valid & instr_ready;
  wire bex_op_t op       = instr.op;
  wire [7:0]    rd_val   = gpr[instr.rd];
  wire [7:0]    rr_val   = gpr[instr.rr];
  wire [7:0]    bitmask  = 8'h01 << instr.bsel;
  wire [4:0]    ptr_lo   = bex_ptr_base(instr.ptr);
  wire [4:0]    ptr_hi   = ptr_lo | 5'h01;
  wire [15:0]   ptr_val  = {gpr[ptr_hi], gpr[ptr_lo]};
  wire [15:0]   ptr_inc  = ptr_val + 16'h0001;
  wire [15:0]   ptr_dec  = ptr_val - 16'h0001;
  wire [15:0]   z_val    = {gpr[PTR_Z_LO | 5'h01], gpr[PTR_Z_LO]};
  wire [15:0]   z_inc    = z_val + 16'h0001;
  wire [8:0]    alu_res  = bex_shift(op, rd_val, status_reg[FL_C]);
  wire          is_shift = op inside {OP_SHIFT_LEFT, OP_SHIFT_RIGHT,
                                      OP_SHIFT_ARITH, OP_ROT_LEFT,
                                      OP_ROT_RIGHT};
  wire          is_load  = op inside {OP_LOAD_IND, OP_LOAD_DISP,
                                      OP_LOAD_DIR, OP_POP};
  wire          is_store = op inside {OP_STORE_IND, OP_STORE_DISP,
                                      OP_STORE_DIR, OP_PUSH};
  wire          is_io_bit = op inside {OP_SET_IO_BIT, OP_CLR_IO_BIT};
  wire          ptr_upd  = (op inside {OP_LOAD_IND, OP_STORE_IND}) &&
                           instr.mode != AM_PLAIN;
  wire [15:0]   ptr_new  = (instr.mode == AM_PRE_DEC) ? ptr_dec : ptr_inc;
  wire          cur_pm   = cur_reg.op == OP_PM_READ;
  wire          bus_gpr_we = reg_we & ~reg_addr[5];

  logic [15:0] ea;
  always_comb begin
    ea = ptr_val;
    case (op)
      OP_LOAD_IND, OP_STORE_IND:
        ea = (instr.mode == AM_PRE_DEC) ? ptr_dec : ptr_val;
      OP_LOAD_DISP, OP_STORE_DISP:
        ea = ptr_val + {10'h000, instr.k[5:0]};
      OP_LOAD_DIR, OP_STORE_DIR:
        ea = instr.k;
      OP_PUSH: ea = sp_reg;
      OP_POP:  ea = sp_reg + 16'h0001;
      default: ea = ptr_val;
    endcase
  end

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  assign instr_ready = (state_reg == ST_IDLE);

  always_comb begin
    state_next = state_reg;
    done_next  = 1'b0;
    unique case (state_reg)
      ST_IDLE: if (accept) begin
        if (is_load || is_store || is_io_bit || op == OP_PM_READ) begin
          state_next = ST_SECOND;
        end else begin
          done_next = 1'b1;
        end
      end
      ST_SECOND: begin
        state_next = cur_pm ? ST_THIRD : ST_IDLE;
        done_next  = ~cur_pm;
      end
      ST_THIRD: begin
        state_next = ST_IDLE;
        done_next  = 1'b1;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // register file write ports
  // ---------------------------------------------------------------
  logic       wa_en, wb_en;
  logic [4:0] wa_idx, wb_idx;
  logic [7:0] wa_data, wb_data;

  always_comb begin
    wa_en   = 1'b0;
    wa_idx  = instr.rd;
    wa_data = alu_res[7:0];
    wb_en   = 1'b0;
    wb_idx  = ptr_hi;
    wb_data = ptr_new[15:8];
    if (state_reg == ST_SECOND && !cur_pm) begin
      wa_en   = (cur_reg.op inside {OP_LOAD_IND, OP_LOAD_DISP,
                                    OP_LOAD_DIR, OP_POP});
      wa_idx  = cur_reg.rd;
      wa_data = dmem_rdata;
    end else if (state_reg == ST_SECOND) begin
      wa_en   = (cur_reg.mode == AM_POST_INC);
      wa_idx  = PTR_Z_LO;
      wa_data = z_inc[7:0];
      wb_en   = wa_en;
      wb_idx  = PTR_Z_LO | 5'h01;
      wb_data = z_inc[15:8];
    end else if (state_reg == ST_THIRD) begin
      wa_en   = 1'b1;
      wa_idx  = cur_reg.rd;
      wa_data = pm_byte_reg;
    end else if (accept) begin
      case (op)
        OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_SHIFT_ARITH, OP_ROT_LEFT,
        OP_ROT_RIGHT, OP_SWAP:
          wa_en = 1'b1;
        OP_T_TO_BIT: begin
          wa_en   = 1'b1;
          wa_data = status_reg[FL_T] ? (rd_val | bitmask)
                                     : (rd_val & ~bitmask);
        end
        OP_COPY: begin
          wa_en   = 1'b1;
          wa_data = rr_val;
        end
        OP_IMM: begin
          wa_en   = 1'b1;
          wa_data = instr.k[7:0];
        end
        OP_PORT_IN: begin
          wa_en   = 1'b1;
          wa_data = io_rdata;
        end
        OP_PAIR_COPY: begin
          wa_en   = 1'b1;
          wa_idx  = instr.rd & 5'h1e;
          wa_data = gpr[instr.rr & 5'h1e];
          wb_en   = 1'b1;
          wb_idx  = instr.rd | 5'h01;
          wb_data = gpr[instr.rr | 5'h01];
        end
        OP_LOAD_IND, OP_STORE_IND: begin
          wa_en   = ptr_upd;
          wa_idx  = ptr_lo;
          wa_data = ptr_new[7:0];
          wb_en   = ptr_upd;
        end
        default: wa_en = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < REG_CNT; i++) gpr[i] <= GPR_RESET;
    end else begin
      if (bus_gpr_we) gpr[reg_addr[4:0]] <= reg_wdata;
      if (wa_en) gpr[wa_idx] <= wa_data;
      if (wb_en) gpr[wb_idx] <= wb_data;
    end
  end

  // ---------------------------------------------------------------
  // status flags and stack pointer
  // ---------------------------------------------------------------
  always_comb begin
    status_next = status_reg;
    if (reg_we && reg_addr == RA_STATUS) status_next = reg_wdata;
    if (accept) begin
      if (is_shift) status_next = bex_shift_flags(status_reg, alu_res);
      if (op == OP_FLAG_SET) status_next = status_reg | bitmask;
      if (op == OP_FLAG_CLR) status_next = status_reg & ~bitmask;
      if (op == OP_BIT_TO_T)
        status_next[FL_T] = rr_val[instr.bsel];
    end
  end

  always_comb begin
    sp_next = sp_reg;
    if (reg_we && reg_addr == RA_SP_LO) sp_next[7:0] = reg_wdata;
    if (reg_we && reg_addr == RA_SP_HI) sp_next[15:8] = reg_wdata;
    if (accept && op == OP_PUSH) sp_next = sp_reg - 16'h0001;
    if (accept && op == OP_POP)  sp_next = sp_reg + 16'h0001;
  end

  // ---------------------------------------------------------------
  // memory and i/o requests
  // ---------------------------------------------------------------
  assign io_raddr = instr.io;
  assign io_re    = accept & (is_io_bit | (op == OP_PORT_IN));

  always_comb begin
    dmem_next    = dmem_reg;
    dmem_next.we = 1'b0;
    dmem_next.re = 1'b0;
    if (accept && (is_load || is_store)) begin
      dmem_next.addr  = ea;
      dmem_next.wdata = rr_val;
      dmem_next.we    = is_store;
      dmem_next.re    = is_load;
    end
    io_wr_next    = io_wr_reg;
    io_wr_next.we = 1'b0;
    if (accept && (is_io_bit || op == OP_PORT_OUT)) begin
      io_wr_next.addr = instr.io;
      io_wr_next.we   = 1'b1;
      io_wr_next.data = (op == OP_PORT_OUT) ? rr_val :
                        (op == OP_SET_IO_BIT) ? (io_rdata | bitmask)
                                              : (io_rdata & ~bitmask);
    end
  end

  wire [7:0] reg_read_mux = ~reg_addr[5]          ? gpr[reg_addr[4:0]] :
                            (reg_addr == RA_STATUS) ? status_reg :
                            (reg_addr == RA_SP_LO)  ? sp_reg[7:0] :
                            (reg_addr == RA_SP_HI)  ? sp_reg[15:8] : 8'h00;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_reg     <= ST_IDLE;
      cur_reg       <= '0;
      status_reg    <= STATUS_RESET;
      sp_reg        <= SP_RESET;
      dmem_reg      <= '0;
      io_wr_reg     <= '0;
      pmem_addr_reg <= 16'h0000;
      pmem_re_reg   <= 1'b0;
      pm_byte_reg   <= 8'h00;
      done_reg      <= 1'b0;
      reg_rdata_reg <= 8'h00;
    end else begin
      state_reg     <= state_next;
      status_reg    <= status_next;
      sp_reg        <= sp_next;
      dmem_reg      <= dmem_next;
      io_wr_reg     <= io_wr_next;
      done_reg      <= done_next;
      reg_rdata_reg <= reg_re ? reg_read_mux : 8'h00;
      pmem_re_reg   <= accept && op == OP_PM_READ;
      if (accept) cur_reg <= instr;
      if (accept && op == OP_PM_READ) pmem_addr_reg <= z_val;
      if (pmem_re_reg) pm_byte_reg <= pmem_rdata;
    end
  end

  assign done         = done_reg;
  assign reg_rdata    = reg_rdata_reg;
  assign dmem_req     = dmem_reg;
  assign io_wr        = io_wr_reg;
  assign pmem_addr    = pmem_addr_reg;
  assign pmem_re      = pmem_re_reg;
  assign status_flags = status_reg;
  assign stack_ptr    = sp_reg;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_io_bit_set: assert property (accept && op == OP_SET_IO_BIT |=>
    io_wr.we && io_wr.data == ($past(io_rdata) | $past(bitmask)))
    else $error("io bit set wrong");
  a_io_bit_len: assert property (accept && is_io_bit |=>
    !instr_ready && status_flags == $past(status_flags) ##1 instr_ready)
    else $error("io bit op length or flags wrong");
  a_shl_flags: assert property (accept && op == OP_SHIFT_LEFT |=>
    status_flags[FL_C] == $past(rd_val[7]) &&
    status_flags[FL_N] == $past(rd_val[6]) && instr_ready)
    else $error("left shift flags wrong");
  a_shr_flags: assert property (accept && op == OP_SHIFT_RIGHT |=>
    status_flags[FL_C] == $past(rd_val[0]) && !status_flags[FL_N])
    else $error("right shift flags wrong");
  a_asr_sign: assert property (accept && op == OP_SHIFT_ARITH |=>
    status_flags[FL_N] == $past(rd_val[7]) &&
    status_flags[FL_C] == $past(rd_val[0]))
    else $error("arithmetic shift flags wrong");
  a_rol_carry: assert property (accept && op == OP_ROT_LEFT |=>
    status_flags[FL_C] == $past(rd_val[7]))
    else $error("rotate left carry wrong");
  a_ror_carry: assert property (accept && op == OP_ROT_RIGHT |=>
    status_flags[FL_N] == $past(status_flags[FL_C]) &&
    status_flags[FL_C] == $past(rd_val[0]))
    else $error("rotate right carry wrong");
  a_flag_only: assert property (accept && op == OP_FLAG_SET |=>
    status_flags == ($past(status_flags) | $past(bitmask)))
    else $error("flag set touched other flags");
  a_bit_store: assert property (accept && op == OP_BIT_TO_T |=>
    status_flags[FL_T] == $past(rr_val[instr.bsel]))
    else $error("transfer flag store wrong");
  a_load_len: assert property (accept && is_load |=>
    dmem_req.re && !instr_ready ##1 instr_ready && !dmem_req.re)
    else $error("load length wrong");
  a_store_dir: assert property (accept && op == OP_STORE_DIR |=>
    dmem_req.we && dmem_req.addr == $past(instr.k))
    else $error("direct store address wrong");
  a_pm_len: assert property (accept && op == OP_PM_READ |=>
    pmem_re && pmem_addr == $past(z_val) ##1 !instr_ready ##1 instr_ready)
    else $error("program memory read length wrong");
  a_push_sp: assert property (accept && op == OP_PUSH |=>
    stack_ptr == $past(stack_ptr) - 16'h0001 &&
    dmem_req.addr == $past(stack_ptr))
    else $error("push stack pointer wrong");

endmodule

/* File: verif/bex_mem_model.sv */
// data memory, i/o space and program memory beside the execution unit
// assumes the unit's strobes are one cycle long and reads are combinational
`timescale 1ns/1ps

module bex_mem_model (
  // clock
  input  wire logic                  clk,
  // data memory
  input  wire bex_pkg::bex_mem_req_t dmem_req,
  output logic [7:0]                 dmem_rdata,
  // i/o space
  input  wire logic [5:0]            io_raddr,
  input  wire logic                  io_re,
  output logic [7:0]                 io_rdata,
  input  wire bex_pkg::bex_io_wr_t   io_wr,
  // program memory
  input  wire logic [15:0]           pmem_addr,
  input  wire logic                  pmem_re,
  output logic [7:0]                 pmem_rdata
);
  import bex_pkg::*;
  // -------------------------------------------------------------
  // storage
  // -------------------------------------------------------------
  logic [7:0] dmem [256];
  logic [7:0] iosp [64];
  logic [7:0] junk_reg = 8'h00;
  always @(posedge clk) begin
    junk_reg <= ~junk_reg ^ 8'h69;
    if (dmem_req.we) begin
      dmem[dmem_req.addr[7:0]] <= dmem_req.wdata;
    end
    if (io_wr.we) begin
      iosp[io_wr.addr] <= io_wr.data;
    end
  end
  // -------------------------------------------------------------
  // read ports, a moving pattern when not strobed
  // -------------------------------------------------------------
  assign dmem_rdata = dmem_req.re ? dmem[dmem_req.addr[7:0]] : junk_reg;
  assign io_rdata   = io_re ? iosp[io_raddr] : ~junk_reg;
  assign pmem_rdata = pmem_re ? pmem_addr[7:0] ^ pmem_addr[15:8] ^ 8'h3c
                              : junk_reg;
endmodule

/* File: verif/bit_and_data_transfer_exec_test.sv */
// self-checking bench of the execution unit
// assumes bex_exec and bex_mem_model; checks go through the register port, the done strobe and the flag and stack pointer outputs
`timescale 1ns/1ps

module bit_and_data_transfer_exec_test;
  import bex_pkg::*;
  // -------------------------------------------------------------
  // signals
  // -------------------------------------------------------------
  logic         clk = 1'b0, rstn = 1'b0, instr_valid = 1'b0;
  logic         reg_we = 1'b0, reg_re = 1'b0, re_seen = 1'b0;
  bex_instr_t   instr = '0;
  logic [5:0]   reg_addr = 6'h00, io_raddr;
  logic [7:0]   reg_wdata = 8'h00, reg_rdata, dmem_rdata, io_rdata;
  logic [7:0]   pmem_rdata, status_flags;
  logic         instr_ready, done, io_re, pmem_re;
  bex_mem_req_t dmem_req;
  bex_io_wr_t   io_wr;
  logic [15:0]  pmem_addr, stack_ptr;
  logic [31:0]  seed = 32'h34;
  logic [7:0]   exp_q[$];
  int           lat_q[$];
  int           n_errors = 0, tests_run = 0, cyc = 0;
  logic [7:0]   ptrv[6] = '{8'h40, 8'h00, 8'h3e, 8'h00, 8'h60, 8'h00};
  bex_op_t      shop[5] = '{OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_SHIFT_ARITH,
                            OP_ROT_LEFT, OP_ROT_RIGHT};

  bex_exec dut (.clk(clk), .rstn(rstn), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .done(done),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata), .dmem_req(dmem_req),
    .dmem_rdata(dmem_rdata), .io_raddr(io_raddr), .io_re(io_re),
    .io_rdata(io_rdata), .io_wr(io_wr), .pmem_addr(pmem_addr),
    .pmem_re(pmem_re), .pmem_rdata(pmem_rdata),
    .status_flags(status_flags), .stack_ptr(stack_ptr));
  bex_mem_model mem (.clk(clk), .dmem_req(dmem_req),
    .dmem_rdata(dmem_rdata), .io_raddr(io_raddr), .io_re(io_re),
    .io_rdata(io_rdata), .io_wr(io_wr), .pmem_addr(pmem_addr),
    .pmem_re(pmem_re), .pmem_rdata(pmem_rdata));

  always #5 clk = ~clk;
  // -------------------------------------------------------------
  // helpers
  // -------------------------------------------------------------
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [7:0] pmb(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    instr_valid <= 1'b0;
    reg_re <= 1'b0;
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    instr_valid <= 1'b0;
    reg_we <= 1'b0;
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
  endtask
  task automatic quiet(input int n);
    instr_valid <= 1'b0;
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic ex(input bex_op_t o, input logic [4:0] d, r,
                    input logic [2:0] b, input logic [15:0] k, input int l,
                    input bex_ptr_t p = PS_NONE,
                    input bex_amode_t m = AM_PLAIN);
    int w;
    w = 0;
    lat_q.push_back(l);
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    instr <= '{o, d, r, b, k[5:0], k, p, m};
    instr_valid <= 1'b1;
    do begin
      @(posedge clk);
      w++;
    end while (instr_ready !== 1'b1 && w < 10);
  endtask
  task automatic cmp_byte(input logic [7:0] g, e);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch at %0t: read %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp_lat(input int g, e);
    tests_run++;
    if (g != e) begin
      n_errors++;
      $display("mismatch at %0t: done after %0d expected %0d", $time, g, e);
    end
  endtask
  task automatic stop_test();
    if (exp_q.size() + lat_q.size() != 0) begin
      n_errors++;
      $display("mismatch at %0t: %0d results never seen", $time,
               exp_q.size() + lat_q.size());
    end
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // -------------------------------------------------------------
  // result watcher and watchdog
  // -------------------------------------------------------------
  always @(posedge clk) begin
    if (re_seen) cmp_byte(reg_rdata, exp_q.pop_front());
    re_seen = reg_re;
    if (done === 1'b1) cmp_lat(cyc, lat_q.pop_front());
    if (instr_valid && instr_ready === 1'b1) cyc = 1;
    else cyc++;
  end
  initial begin
    #100000;
    n_errors++;
    stop_test();
  end
  // -------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------
  initial begin
    logic [7:0] v, s, e, f;
    int i;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(RA_STATUS, STATUS_RESET);
    rd(RA_SP_LO, SP_RESET[7:0]);
    rd(6'h05, GPR_RESET);
    wr(6'h3f, 8'h5a);
    rd(6'h3f, 8'h00);
    for (i = 0; i < 5; i++) begin
      v = rnd();
      s = rnd();
      wr(6'h03, v);
      wr(RA_STATUS, s);
      ex(shop[i], 5'h03, 5'h00, 3'h0, 16'h0000, 1);
      case (i)
        0: {f[0], e} = {v, 1'b0};
        1: {e, f[0]} = {1'b0, v};
        2: {e, f[0]} = {v[7], v};
        3: {f[0], e} = {v, s[0]};
        default: {e, f[0]} = {s[0], v};
      endcase
      f = {s[7:4], e[7] ^ f[0], e[7], e == 8'h00, f[0]};
      rd(6'h03, e);
      rd(RA_STATUS, f);
    end
    for (i = 0; i < 8; i++) begin
      s = rnd();
      wr(RA_STATUS, s);
      ex(OP_FLAG_SET, 5'h00, 5'h00, i[2:0], 16'h0000, 1);
      ex(OP_FLAG_CLR, 5'h00, 5'h00, i[2:0] + 3'h1, 16'h0000, 1);
      rd(RA_STATUS, (s | 8'h01 << i) & ~(8'h01 << ((i + 1) % 8)));
    end
    v = rnd();
    e = rnd();
    wr(6'h02, v);
    wr(6'h06, e);
    ex(OP_BIT_TO_T, 5'h00, 5'h02, 3'h5, 16'h0000, 1);
    ex(OP_T_TO_BIT, 5'h06, 5'h00, 3'h2, 16'h0000, 1);
    e[2] = v[5];
    s = (s | 8'h01 << 7) & 8'hfe;
    s[6] = v[5];
    rd(RA_STATUS, s);
    rd(6'h06, e);
    v = rnd();
    wr(6'h07, v);
    ex(OP_PORT_OUT, 5'h00, 5'h07, 3'h0, 16'h0011, 1);
    quiet(1);
    ex(OP_SET_IO_BIT, 5'h00, 5'h00, 3'h3, 16'h0011, 2);
    ex(OP_CLR_IO_BIT, 5'h00, 5'h00, 3'h6, 16'h0011, 2);
    quiet(1);
    ex(OP_PORT_IN, 5'h08, 5'h00, 3'h0, 16'h0011, 1);
    v[3] = 1'b1;
    v[6] = 1'b0;
    rd(6'h08, v);
    for (i = 0; i < 6; i++) wr(6'h1a + i[5:0], ptrv[i]);
    v = rnd();
    e = rnd();
    wr(6'h04, v);
    wr(6'h09, e);
    wr(RA_SP_LO, 8'hff);
    ex(OP_STORE_IND, 5'h00, 5'h04, 3'h0, 16'h0, 2, PS_X, AM_POST_INC);
    ex(OP_STORE_IND, 5'h00, 5'h09, 3'h0, 16'h0000, 2, PS_X);
    ex(OP_LOAD_IND, 5'h05, 5'h00, 3'h0, 16'h0000, 2, PS_X, AM_PRE_DEC);
    ex(OP_LOAD_DISP, 5'h06, 5'h00, 3'h0, 16'h0003, 2, PS_Y);
    ex(OP_STORE_DISP, 5'h00, 5'h04, 3'h0, 16'h0002, 2, PS_Z);
    ex(OP_STORE_DIR, 5'h00, 5'h09, 3'h0, 16'h0050, 2);
    ex(OP_LOAD_DIR, 5'h0a, 5'h00, 3'h0, 16'h0062, 2);
    ex(OP_LOAD_DIR, 5'h0b, 5'h00, 3'h0, 16'h0050, 2);
    ex(OP_PUSH, 5'h00, 5'h05, 3'h0, 16'h0000, 2);
    ex(OP_PUSH, 5'h00, 5'h06, 3'h0, 16'h0000, 2);
    ex(OP_POP, 5'h0c, 5'h00, 3'h0, 16'h0000, 2);
    ex(OP_POP, 5'h0d, 5'h00, 3'h0, 16'h0000, 2);
    ex(OP_STORE_IND, 5'h00, 5'h04, 3'h0, 16'h0, 2, PS_Y, AM_PRE_DEC);
    ex(OP_LOAD_IND, 5'h16, 5'h00, 3'h0, 16'h0, 2, PS_Y, AM_POST_INC);
    quiet(2);
    rd(6'h05, v);
    rd(6'h06, e);
    rd(6'h0a, v);
    rd(6'h0b, e);
    rd(6'h1a, 8'h40);
    rd(6'h1c, 8'h3e);
    rd(6'h1e, 8'h60);
    rd(6'h0c, e);
    rd(6'h0d, v);
    rd(6'h16, v);
    rd(RA_SP_LO, 8'hff);
    wr(6'h1e, 8'h23);
    wr(6'h1f, 8'h01);
    ex(OP_PM_READ, PM_DEFAULT_RD, 5'h00, 3'h0, 16'h0000, 3, PS_Z);
    ex(OP_PM_READ, 5'h0e, 5'h00, 3'h0, 16'h0000, 3, PS_Z, AM_POST_INC);
    ex(OP_PM_READ, 5'h0f, 5'h00, 3'h0, 16'h0000, 3, PS_Z, AM_POST_INC);
    quiet(3);
    rd(6'h00, pmb(16'h0123));
    rd(6'h0e, pmb(16'h0123));
    rd(6'h0f, pmb(16'h0124));
    rd(6'h1e, 8'h25);
    v = rnd();
    e = rnd();
    f = rnd();
    wr(6'h10, v);
    wr(6'h11, e);
    ex(OP_PAIR_COPY, 5'h12, 5'h10, 3'h0, 16'h0000, 1);
    ex(OP_COPY, 5'h14, 5'h11, 3'h0, 16'h0000, 1);
    ex(OP_IMM, 5'h15, 5'h00, 3'h0, {8'h00, f}, 1);
    ex(OP_SWAP, 5'h10, 5'h00, 3'h0, 16'h0, 1);
    rd(6'h12, v);
    rd(6'h13, e);
    rd(6'h14, e);
    rd(6'h15, f);
    rd(6'h10, {v[3:0], v[7:4]});
    rd(RA_STATUS, s);
    quiet(3);
    cmp_byte(status_flags, s);
    cmp_byte(stack_ptr[7:0], 8'hff);
    cmp_byte(stack_ptr[15:8], 8'h00);
    stop_test();
  end
endmodule
